// *** src/dfll_calibration_control.sv ***
// Purpose: oscillator trim registers with frequency-locked loop
// Assumes: ref and oscillator strobes synchronous to clk_sys
// Notes: AHB-Lite slave, zero wait states while ce is high
`timescale 1ns/1ps
`include "dfll_params.svh"

module dfll_calibration_control #(
  parameter bit LOOP_IS_FAST = 1'b1,
  parameter int REF_DIV = `REF_DIV
)(
  // clock, reset, clock enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reference clocks and oscillator cycle strobe
  input wire logic internal32kReference,
  input wire logic crystal32kReference,
  input wire logic oscCycle,
  // factory trim from signature row
  input wire logic [6:0] factoryFine,
  input wire logic [5:0] factoryRange,
  // oscillator trim
  output logic [6:0] trimFineField,
  output logic [5:0] trimRangeField,
  output dfll_pkg::fast_ref_t fastOscRefSelect,
  output logic slowOscRefSelect
);
  import dfll_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [5:0] DIV_LAST = 6'(REF_DIV - 1);
  loop_state_t state_r, state_nxt;
  logic enReq_r, loadPend_r, refPrev_r, slowSel_r;
  logic [1:0] fastSel_r;
  logic [6:0] fine_r, fine_nxt;
  logic [5:0] range_r, divCnt_r;
  logic [15:0] ratio_r, oscCnt_r, lastCount_r;
  logic dphWr_r;
  logic [7:0] dphIdx_r;

  function automatic logic [7:0] regIdx(input logic [31:0] a);
    regIdx = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'hff;
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire addrPhase = ce && hsel && hready && htrans[1];
  wire [7:0] aIdx = regIdx(haddr);
  wire wrPhase = ce && dphWr_r;
  wire enRead = enReq_r || (state_r != ST_IDLE);
  wire wrCtrl = wrPhase && dphIdx_r == `IDX_LOOP_CONTROL;
  wire wrFine = wrPhase && dphIdx_r == `IDX_TRIM_FINE;
  wire wrRange = wrPhase && dphIdx_r == `IDX_TRIM_RANGE;
  wire wrLow = wrPhase && dphIdx_r == `IDX_RATIO_LOW;
  wire wrHigh = wrPhase && dphIdx_r == `IDX_RATIO_HIGH;
  wire wrRef = wrPhase && dphIdx_r == `IDX_REF_SELECT;
  wire trimWrOk = !enRead && !loadPend_r;
  wire [31:0] rdMux =
    (aIdx == `IDX_LOOP_CONTROL) ? {31'h0, enRead} :
    (aIdx == `IDX_TRIM_FINE) ? {25'h0, fine_r} :
    (aIdx == `IDX_TRIM_RANGE) ? {26'h0, range_r} :
    (aIdx == `IDX_RATIO_LOW) ? {24'h0, ratio_r[7:0]} :
    (aIdx == `IDX_RATIO_HIGH) ? {24'h0, ratio_r[15:8]} :
    (aIdx == `IDX_REF_SELECT) ? {29'h0, fastSel_r, slowSel_r} :
    (aIdx == `IDX_LOOP_STATUS) ? {16'h0, lastCount_r} : 32'h0;

  assign hreadyout = ce;
  assign hresp = 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dphWr_r <= 1'b0;
      dphIdx_r <= 8'h00;
      hrdata <= 32'h0;
    end
    else if (ce)
    begin
      dphWr_r <= addrPhase && hwrite;
      dphIdx_r <= aIdx;
      if (addrPhase && !hwrite)
        hrdata <= rdMux;
    end
  end

  // ----------------------------------------
  // reference routing
  // ----------------------------------------
  // reserved fast codes route no reference, so a fast loop (LOOP_IS_FAST) stalls
  wire fastRef = (fastSel_r == REF_INT32K) ? internal32kReference :
    (fastSel_r == REF_XTAL32K) ? crystal32kReference : 1'b0;
  wire slowRef = slowSel_r ? crystal32kReference :
    internal32kReference;
  wire selRef = LOOP_IS_FAST ? fastRef : slowRef;
  wire refEdge = selRef && !refPrev_r;
  assign fastOscRefSelect = fast_ref_t'(fastSel_r);
  assign slowOscRefSelect = slowSel_r;

  // ----------------------------------------
  // loop sequencing
  // ----------------------------------------
  wire periodEnd = state_r == ST_MEAS && refEdge
    && divCnt_r == DIV_LAST;
  wire upd = ce && periodEnd;
  // the strobe sampled at the closing edge still counts for that period
  wire [15:0] oscTotal = (oscCycle && oscCnt_r != 16'hffff) ?
    oscCnt_r + 16'h0001 : oscCnt_r;
  wire cntHigh = oscTotal > ratio_r;
  wire cntLow = oscTotal < ratio_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (enReq_r)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (!enReq_r)
          state_nxt = ST_IDLE;
        else if (refEdge)
          state_nxt = ST_MEAS;
      ST_MEAS:
        if (periodEnd && !enReq_r)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // step fine trim, saturating at its ends
  always_comb
  begin
    fine_nxt = fine_r;
    if (loadPend_r)
      fine_nxt = factoryFine;
    else if (upd && cntHigh && fine_r != 7'h00)
      fine_nxt = fine_r - 7'h01;
    else if (upd && cntLow && fine_r != `FINE_MAX)
      fine_nxt = fine_r + 7'h01;
    else if (wrFine && trimWrOk)
      fine_nxt = hwdata[6:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      refPrev_r <= 1'b0;
      divCnt_r <= 6'h00;
      oscCnt_r <= 16'h0000;
      lastCount_r <= 16'h0000;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      refPrev_r <= selRef;
      if (state_r != ST_MEAS || periodEnd)
      begin
        divCnt_r <= 6'h00;
        oscCnt_r <= 16'h0000;
      end
      else
      begin
        if (refEdge)
          divCnt_r <= divCnt_r + 6'h01;
        oscCnt_r <= oscTotal;
      end
      if (periodEnd)
        lastCount_r <= oscTotal;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      loadPend_r <= 1'b1;
      fine_r <= `RST_FINE;
      range_r <= `RST_RANGE;
    end
    else if (ce)
    begin
      loadPend_r <= 1'b0;
      fine_r <= fine_nxt;
      if (loadPend_r)
        range_r <= factoryRange;
      else if (wrRange && trimWrOk)
        range_r <= hwdata[5:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enReq_r <= `RST_ENABLE;
      ratio_r <= `RST_RATIO;
      fastSel_r <= `RST_FAST_REF;
      slowSel_r <= `RST_SLOW_REF;
    end
    else if (ce)
    begin
      if (wrCtrl)
        enReq_r <= hwdata[`POS_ENABLE];
      if (wrLow)
        ratio_r[7:0] <= hwdata[7:0];
      if (wrHigh)
        ratio_r[15:8] <= hwdata[7:0];
      if (wrRef)
      begin
        fastSel_r <= hwdata[`POS_FAST_REF +: 2];
        slowSel_r <= hwdata[`POS_SLOW_REF];
      end
    end
  end

  // 13-bit trim drives the oscillator directly
  assign trimFineField = fine_r;
  assign trimRangeField = range_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence loopOn;
    ce && state_r == ST_IDLE && enReq_r;
  endsequence
  sequence waitRef;
    state_r == ST_WAIT;
  endsequence

  fast_ref_route_a: assert property (
    LOOP_IS_FAST && fastSel_r == 2'h1 |-> selRef == crystal32kReference)
    else $error("fast reference routing wrong");
  slow_ref_route_a: assert property (
    !LOOP_IS_FAST && !slowSel_r |-> selRef == internal32kReference)
    else $error("slow reference routing wrong");
  loop_start_a: assert property (
    loopOn |=> waitRef)
    else $error("loop did not start");
  trim_write_a: assert property (
    wrFine && trimWrOk |=> fine_r == $past(hwdata[6:0]))
    else $error("fine write lost while loop off");
  write_block_a: assert property (
    wrRange && enRead |=> $stable(range_r))
    else $error("range written while loop on");
  factory_load_a: assert property (
    !rst && ce && loadPend_r |=> fine_r == $past(factoryFine)
      && range_r == $past(factoryRange))
    else $error("factory trim not loaded");
  range_fixed_a: assert property (
    ce && state_r != ST_IDLE && !wrRange |=> $stable(range_r))
    else $error("loop changed range");
  step_down_a: assert property (
    upd && cntHigh && fine_r != 7'h00 |=> fine_r == $past(fine_r) - 7'h01)
    else $error("fine not stepped down");
  step_sat_a: assert property (
    upd && cntLow && fine_r == `FINE_MAX |=> fine_r == `FINE_MAX)
    else $error("fine did not saturate");
  enable_hold_a: assert property (
    ce && state_r == ST_MEAS && !enReq_r && !periodEnd |=> state_r == ST_MEAS)
    else $error("enable read zero mid update");
  step_up_a: assert property (
    upd && cntLow && fine_r != `FINE_MAX |=> fine_r == $past(fine_r) + 7'h01)
    else $error("fine not stepped up");
  fast_int_route_a: assert property (
    LOOP_IS_FAST && fastSel_r == 2'h0 |-> selRef == internal32kReference)
    else $error("fast internal routing wrong");
  reserved_route_a: assert property (
    LOOP_IS_FAST && fastSel_r[1] |-> !selRef)
    else $error("reserved code routed a reference");
  idle_trim_a: assert property (
    ce && state_r == ST_IDLE && !loadPend_r && !wrFine |=> $stable(fine_r))
    else $error("fine moved while loop off");
  ratio_write_a: assert property (
    wrHigh |=> ratio_r[15:8] == $past(hwdata[7:0]))
    else $error("ratio high byte not written");
  period_len_a: assert property (
    divCnt_r <= DIV_LAST)
    else $error("reference divider overran");
endmodule

// *** src/dfll_params.svh ***
// Purpose: constants for the frequency-locked loop trim block
// Assumes: register indices, byte address is four times the index
// Notes: included by the design and the bench
`ifndef DFLL_PARAMS_SVH
`define DFLL_PARAMS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_LOOP_CONTROL 8'h00
`define IDX_TRIM_FINE 8'h02
`define IDX_TRIM_RANGE 8'h03
`define IDX_RATIO_LOW 8'h05
`define IDX_RATIO_HIGH 8'h06
`define IDX_REF_SELECT 8'h08
`define IDX_LOOP_STATUS 8'h09

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define POS_ENABLE 0
`define POS_SLOW_REF 0
`define POS_FAST_REF 1
`define RST_ENABLE 1'b0
`define RST_RATIO 16'h0000
`define RST_FAST_REF 2'h0
`define RST_SLOW_REF 1'b0
`define RST_FINE 7'h00
`define RST_RANGE 6'h00
`define FINE_MAX 7'h7f

// ----------------------------------------
// timing
// ----------------------------------------
`define REF_HZ 32768
`define CMP_HZ 1024
`define REF_DIV (`REF_HZ / `CMP_HZ)

`endif

// *** src/dfll_pkg.sv ***
// Purpose: types for the frequency-locked loop trim block
// Assumes: constants come from dfll_params.svh
// Notes: none
package dfll_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MEAS} loop_state_t;
  typedef enum logic [1:0] {
    REF_INT32K = 2'h0,
    REF_XTAL32K = 2'h1
  } fast_ref_t;
endpackage

// *** tb/dfll_calibration_control_bench.sv ***
// Purpose: self-checking bench for the trim block
// Assumes: ahb-lite single word transfers, byte address four times index
// Notes: shortened reference divider keeps loop periods brief
`timescale 1ns/1ps
`include "dfll_params.svh"

module dfll_calibration_control_bench;
  import dfll_pkg::*;
  logic clk_sys, rst, ce, hsel, hwrite, hreadyout, hresp, slowSel;
  logic intRef, xtalRef, oscCycle;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [6:0] fine, facFine;
  logic [5:0] range, facRange;
  fast_ref_t fastSel;
  int errCount = 0;
  int checkCount = 0;

  dfll_calibration_control #(.LOOP_IS_FAST(1'b1), .REF_DIV(4)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .internal32kReference(intRef),
    .crystal32kReference(xtalRef), .oscCycle(oscCycle),
    .factoryFine(facFine), .factoryRange(facRange), .trimFineField(fine),
    .trimRangeField(range), .fastOscRefSelect(fastSel),
    .slowOscRefSelect(slowSel));

  ref_osc_model #(.HALF(4)) u_ref (.clk_sys(clk_sys), .rst(rst),
    .internal32kReference(intRef), .crystal32kReference(xtalRef),
    .oscCycle(oscCycle));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction

  task automatic closeOut();
    $display("mismatches %0d of %0d checks", errCount, checkCount);
    if (errCount == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic waitReady();
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1)
    begin
      errCount++;
      closeOut();
    end
  endtask

  // one single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask

  task automatic stopLoop();
    int k;
    bus(1'b1, ad(`IDX_LOOP_CONTROL), 32'h0);
    k = 0;
    do
    begin
      bus(1'b0, ad(`IDX_LOOP_CONTROL), 32'h0);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 40);
    if (rd[0] !== 1'b0)
    begin
      errCount++;
      closeOut();
    end
    check("enable clears", rd, 32'h0);
  endtask

  task automatic tResetValues();
    logic [7:0] idx [6];
    logic [31:0] exp [6];
    idx = '{`IDX_TRIM_FINE, `IDX_TRIM_RANGE, `IDX_LOOP_CONTROL,
            `IDX_RATIO_LOW, `IDX_RATIO_HIGH, 8'h01};
    exp = '{32'h55, 32'h2a, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, ad(idx[i]), 32'h0);
      check("reset value", rd, exp[i]);
    end
    check("fine pin", fine, 7'h55);
    check("range pin", range, 6'h2a);
  endtask

  task automatic tManualTrim();
    bus(1'b1, ad(`IDX_TRIM_FINE), 32'h40);
    bus(1'b1, ad(`IDX_TRIM_RANGE), 32'h15);
    @(posedge clk_sys);
    check("bus okay", hresp, 1'b0);
    check("fine pin", fine, 7'h40);
    check("range pin", range, 6'h15);
    bus(1'b0, ad(`IDX_TRIM_RANGE), 32'h0);
    check("range reg", rd, 32'h15);
  endtask

  task automatic tRefSelect();
    for (int v = 7; v >= 0; v--)
    begin
      bus(1'b1, ad(`IDX_REF_SELECT), 32'(v));
      @(posedge clk_sys);
      check("fast sel", fastSel, v[2:1]);
      check("slow sel", slowSel, v[0]);
    end
  endtask

  task automatic tLoopUp();
    bus(1'b1, ad(`IDX_TRIM_FINE), 32'h40);
    bus(1'b1, ad(`IDX_RATIO_LOW), 32'hff);
    bus(1'b1, ad(`IDX_RATIO_HIGH), 32'hff);
    bus(1'b1, ad(`IDX_LOOP_CONTROL), 32'h1);
    bus(1'b0, ad(`IDX_LOOP_CONTROL), 32'h0);
    check("enable reg", rd, 32'h1);
    bus(1'b1, ad(`IDX_TRIM_RANGE), 32'h3f);
    bus(1'b1, ad(`IDX_TRIM_FINE), 32'h00);
    repeat (300) @(posedge clk_sys);
    check("range held", range, 6'h15);
    check("fine rose", fine > 7'h40, 1'b1);
    // four reference periods of 8 clocks, strobe every other clock
    bus(1'b0, ad(`IDX_LOOP_STATUS), 32'h0);
    check("period count", rd, 32'h10);
    stopLoop();
  endtask

  task automatic tClockEnable();
    logic [6:0] held;
    bus(1'b1, ad(`IDX_LOOP_CONTROL), 32'h1);
    repeat (100) @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    held = fine;
    check("ready low", hreadyout, 1'b0);
    repeat (100) @(posedge clk_sys);
    check("fine held", fine, held);
    ce <= 1'b1;
    repeat (100) @(posedge clk_sys);
    check("fine moves", fine > held, 1'b1);
    stopLoop();
  endtask

  task automatic tMidReset();
    bus(1'b1, ad(`IDX_RATIO_LOW), 32'h12);
    bus(1'b1, ad(`IDX_REF_SELECT), 32'h7);
    facFine <= 7'h33;
    facRange <= 6'h0c;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bus(1'b0, ad(`IDX_RATIO_LOW), 32'h0);
    check("ratio after reset", rd, 32'h0);
    check("fine after reset", fine, 7'h33);
    check("range after reset", range, 6'h0c);
    check("fast sel reset", fastSel, 2'h0);
    check("slow sel reset", slowSel, 1'b0);
  endtask

  task automatic tSaturate();
    logic [6:0] held;
    held = fine;
    repeat (100) @(posedge clk_sys);
    check("fine frozen", fine, held);
    bus(1'b1, ad(`IDX_TRIM_FINE), 32'h7e);
    bus(1'b1, ad(`IDX_LOOP_CONTROL), 32'h1);
    repeat (200) @(posedge clk_sys);
    check("fine top", fine, 7'h7f);
    stopLoop();
    bus(1'b1, ad(`IDX_RATIO_LOW), 32'h0);
    bus(1'b1, ad(`IDX_RATIO_HIGH), 32'h0);
    bus(1'b1, ad(`IDX_TRIM_FINE), 32'h01);
    bus(1'b1, ad(`IDX_LOOP_CONTROL), 32'h1);
    repeat (200) @(posedge clk_sys);
    check("fine bottom", fine, 7'h00);
    stopLoop();
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    facFine = 7'h55;
    facRange = 6'h2a;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    tResetValues();
    tManualTrim();
    tRefSelect();
    tLoopUp();
    tClockEnable();
    tSaturate();
    tMidReset();
    closeOut();
  end
endmodule

// *** tb/ref_osc_model.sv ***
// Purpose: reference clocks and oscillator cycle strobe for the trim block
// Assumes: both references already enabled and settled by software
// Notes: crystal runs one clock slower per half period than internal
`timescale 1ns/1ps

module ref_osc_model #(
  parameter int HALF = 4
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // references and strobe
  output logic internal32kReference,
  output logic crystal32kReference,
  output logic oscCycle
);
  int intCnt;
  int xtalCnt;

  // references free run from reset on, so the loop waits at most one reference period in ST_WAIT
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      intCnt <= 0;
      xtalCnt <= 0;
      internal32kReference <= 1'b0;
      crystal32kReference <= 1'b0;
      oscCycle <= 1'b0;
    end
    else
    begin
      intCnt <= (intCnt == HALF - 1) ? 0 : intCnt + 1;
      xtalCnt <= (xtalCnt == HALF) ? 0 : xtalCnt + 1;
      if (intCnt == HALF - 1)
        internal32kReference <= ~internal32kReference;
      if (xtalCnt == HALF)
        crystal32kReference <= ~crystal32kReference;
      oscCycle <= ~oscCycle;
    end
  end
endmodule
